/* core/hdp_pkg.sv */
// Package of constants and carrier types for the host data port handshake
// ****************************************************************
// Overview of operation
// - Bus address timeout sets status bit 8; fatal until reinitialized.
// - Host procedure error sets status bit 9; fatal until reinitialized.
// - Device may seize an idle port; host must request before input.
// - Device sets command bit 7 once the port is granted.
// - Host loads port, drops request; device consumes data, clears grant.
// - Command bit 6 interrupts at first vector while grant is set.
// - Output starts only when port is neither granted nor busy.
// - After soft clear or bus init, no output until initialized.
// - Output loads port, format code, then sets response bit 7.
// - Response bit 6 interrupts at second vector after ready sets.
// - Pending input request is not granted while output is unacknowledged.
// - Power-up, bus init or soft clear restart; no line or output activity.
// - Base input: type 11, address in low word and bits 15:14, bit 12.
// - Base table belongs to device until the next clear.
// - Control input: bit 10 half duplex, bit 11 secondary, longer interval.
// - Link start-up begins within one timer interval of a base input with bit 12 clear.
// - In running state, peer restart is reported with high-word bit 7.
// - Status output has format bit 1 clear, bit 0 set; errors high word.
// ****************************************************************
package hdp_pkg;

  // Clock and timing
  localparam int CLK_MHZ      = 100;
  localparam int CLR_HOLD_NS  = 2000;
  localparam int CLR_HOLD_CYC = (CLR_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_PRI_MS   = 1000;
  localparam int TMR_SEC_MS   = 3000;
  localparam int TMR_PRI_CYC  = TMR_PRI_MS * CLK_MHZ * 1000;
  localparam int TMR_SEC_CYC  = TMR_SEC_MS * CLK_MHZ * 1000;

  // Byte addresses of the host port
  localparam logic [2:0] ADDR_CMD   = 3'h0;
  localparam logic [2:0] ADDR_MAINT = 3'h1;
  localparam logic [2:0] ADDR_RESP  = 3'h2;
  localparam logic [2:0] ADDR_DATA  = 3'h4;

  // Field positions
  localparam int CMD_REQ_BIT  = 5;
  localparam int CMD_IEN_BIT  = 6;
  localparam int CMD_GNT_BIT  = 7;
  localparam int RESP_IEN_BIT = 6;
  localparam int RESP_RDY_BIT = 7;
  localparam int MAINT_CLR_BIT = 6;
  localparam int HW_ST_PEER   = 7;
  localparam int HW_ST_TMO    = 8;
  localparam int HW_ST_PROC   = 9;
  localparam int HW_HD_BIT    = 10;
  localparam int HW_SEC_BIT   = 11;
  localparam int HW_RESUME    = 12;
  localparam int HW_ADDR_LSB  = 14;

  // Transfer codes, low two bits of the type or format field
  localparam logic [1:0] CODE_BACC   = 2'h0;
  localparam logic [1:0] CODE_CTL    = 2'h1;
  localparam logic [1:0] CODE_BAD    = 2'h2;
  localparam logic [1:0] CODE_BASE   = 2'h3;
  localparam logic [2:0] FMT_STATUS  = 3'h1;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;

  // Port transfer: three-bit code and the four data port bytes
  typedef struct packed {
    logic [2:0]  code;
    logic [31:0] data;
  } hdp_xfer_t;

endpackage

/* core/hdp_reset_ctl.sv */
// Reset synchroniser and clear stretcher for the host data port
`timescale 1ns/1ns
module hdp_reset_ctl #(
  parameter int HOLD_CYC = hdp_pkg::CLR_HOLD_CYC
) (
  // Clock and raw reset
  input  wire logic i_clk_sys,
  input  wire logic i_reset_n,
  // Clear requests, soft clear or bus init
  input  wire logic i_clear_req,
  // Synchronised reset and stretched clear
  output logic      o_rst_n,
  output logic      o_clear
);
  import hdp_pkg::*;

  localparam int CW = $clog2(HOLD_CYC + 1);

  logic          sync_a_r;
  logic          sync_b_r;
  logic [CW-1:0] hold_r;

  if (HOLD_CYC < 1) begin : g_bad_hold
    $error("hdp_reset_ctl: HOLD_CYC must be at least 1");
  end

  // Release reset through two flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync_a_r <= 1'b0;
      sync_b_r <= 1'b0;
    end else begin
      sync_a_r <= 1'b1;
      sync_b_r <= sync_a_r;
    end
  end
  assign o_rst_n = sync_b_r;

  // Hold the block in clear while the restart settles
  always_ff @(posedge i_clk_sys or negedge sync_b_r) begin
    if (!sync_b_r) begin
      hold_r <= '0;
    end else if (i_clear_req) begin
      hold_r <= CW'(HOLD_CYC);
    end else if (hold_r != '0) begin
      hold_r <= hold_r - 1'b1;
    end
  end
  assign o_clear = i_clear_req || (hold_r != '0);

endmodule

/* core/hdp_interval_timer.sv */
// Start-up interval timer, short for primary and long for secondary
`timescale 1ns/1ns
module hdp_interval_timer #(
  parameter int PRI_CYC = hdp_pkg::TMR_PRI_CYC,
  parameter int SEC_CYC = hdp_pkg::TMR_SEC_CYC
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_restart,
  input  wire logic i_long,
  // One-cycle tick at the end of each interval
  output logic      o_tick
);
  import hdp_pkg::*;

  logic [31:0] cnt_r;
  logic [31:0] limit;

  if (PRI_CYC < 2 || SEC_CYC < PRI_CYC) begin : g_bad_interval
    $error("hdp_interval_timer: bad interval");
  end

  assign limit  = i_long ? 32'(SEC_CYC - 1) : 32'(PRI_CYC - 1);
  assign o_tick = (cnt_r >= limit);

  // Free-running interval counter
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= WORD_ZERO;
    end else if (i_restart || o_tick) begin
      cnt_r <= WORD_ZERO;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

endmodule

/* core/hdp_port_ctrl.sv */
// Host data port handshake: command, response and data port bytes
`timescale 1ns/1ns
module hdp_port_ctrl #(
  parameter int TMR_PRI = hdp_pkg::TMR_PRI_CYC,
  parameter int TMR_SEC = hdp_pkg::TMR_SEC_CYC
) (
  // Clock and resets
  input  wire logic             i_clk_sys,
  input  wire logic             i_reset_n,
  input  wire logic             i_bus_init,
  // Host register port, byte addressed
  input  wire logic [2:0]       i_host_addr,
  input  wire logic             i_host_wr,
  input  wire logic             i_host_rd,
  input  wire logic [7:0]       i_host_wdata,
  output logic      [7:0]       o_host_rdata,
  // Host interrupt requests, first and second vector
  output logic                  o_irq_in_vec,
  output logic                  o_irq_out_vec,
  // Engine side transfers
  input  wire logic             i_out_valid,
  input  wire hdp_pkg::hdp_xfer_t i_out_xfer,
  output logic                  o_out_ready,
  output logic                  o_in_valid,
  output hdp_pkg::hdp_xfer_t    o_in_xfer,
  // Engine events
  input  wire logic             i_bus_timeout,
  input  wire logic             i_peer_restart,
  input  wire logic             i_link_running,
  // Configuration and state
  output logic      [17:0]      o_base_addr,
  output logic                  o_resume,
  output logic                  o_half_duplex,
  output logic                  o_secondary,
  output logic                  o_link_start,
  output logic                  o_online,
  output logic                  o_fatal
);
  import hdp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_IN_GRANT, ST_OUT_BUSY} hdp_state_t;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        rst_n;
  logic        clr;
  logic        soft_clr_r;
  logic        tick;
  hdp_state_t  state_r;
  logic [2:0]  in_type_r;
  logic        in_req_r;
  logic        in_ien_r;
  logic        out_ien_r;
  logic [2:0]  out_fmt_r;
  logic [31:0] data_r;
  logic        base_r;
  logic        start_pend_r;
  logic [15:0] stat_r;
  logic        stat_pend_r;
  logic        grant_go;
  logic        out_go;
  logic        stat_go;
  logic        consume;
  logic        procedure_error;
  logic        host_wr;

  // Byte lane of a data port address
  function automatic logic [4:0] lane_lsb(input logic [2:0] a);
    lane_lsb = {a[1:0], 3'h0};
  endfunction

  // ****************************************************************
  // Reset, clear and interval timer
  // ****************************************************************
  hdp_reset_ctl #(.HOLD_CYC(CLR_HOLD_CYC)) u_rst (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_clear_req (soft_clr_r || i_bus_init),
    .o_rst_n     (rst_n),
    .o_clear     (clr)
  );

  hdp_interval_timer #(.PRI_CYC(TMR_PRI), .SEC_CYC(TMR_SEC)) u_tmr (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_restart (clr || consume),
    .i_long    (o_secondary),
    .o_tick    (tick)
  );

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // Input wins an idle port; output only when free and initialized
  assign host_wr  = i_host_wr && !clr;
  assign grant_go = (state_r == ST_IDLE) && in_req_r && !o_fatal;
  assign stat_go  = (state_r == ST_IDLE) && !in_req_r && base_r && stat_pend_r;
  assign o_out_ready = (state_r == ST_IDLE) && !in_req_r && base_r && !stat_pend_r
                       && !o_fatal && !clr;
  assign out_go   = o_out_ready && i_out_valid;
  assign consume  = (state_r == ST_IN_GRANT) && !in_req_r;
  assign procedure_error = consume && ((in_type_r[1:0] == CODE_BAD)
                    || (in_type_r[1:0] == CODE_BASE && base_r)
                    || (in_type_r[1:0] != CODE_BASE && !base_r));

  // Port ownership state
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else if (clr) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (grant_go) begin
            state_r <= ST_IN_GRANT;
          end else if (stat_go || out_go) begin
            state_r <= ST_OUT_BUSY;
          end
        end
        ST_IN_GRANT: begin
          if (consume) begin
            state_r <= ST_IDLE;
          end
        end
        ST_OUT_BUSY: begin
          if (host_wr && i_host_addr == ADDR_RESP && !i_host_wdata[RESP_RDY_BIT]) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Host writable command and response bits
  // ****************************************************************
  // Type code, request and input interrupt enable
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      in_type_r <= 3'h0;
      in_req_r  <= 1'b0;
      in_ien_r  <= 1'b0;
    end else if (clr) begin
      in_type_r <= 3'h0;
      in_req_r  <= 1'b0;
      in_ien_r  <= 1'b0;
    end else if (host_wr && i_host_addr == ADDR_CMD) begin
      in_type_r <= i_host_wdata[2:0];
      in_req_r  <= i_host_wdata[CMD_REQ_BIT];
      in_ien_r  <= i_host_wdata[CMD_IEN_BIT];
    end
  end

  // Output interrupt enable
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_ien_r <= 1'b0;
    end else if (clr) begin
      out_ien_r <= 1'b0;
    end else if (host_wr && i_host_addr == ADDR_RESP) begin
      out_ien_r <= i_host_wdata[RESP_IEN_BIT];
    end
  end

  // Soft clear strobe from the maintenance byte
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      soft_clr_r <= 1'b0;
    end else begin
      soft_clr_r <= i_host_wr && i_host_addr == ADDR_MAINT
                    && i_host_wdata[MAINT_CLR_BIT];
    end
  end

  // ****************************************************************
  // Data port and format code
  // ****************************************************************
  // Host loads bytes while granted, device loads on output
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      data_r    <= WORD_ZERO;
      out_fmt_r <= 3'h0;
    end else if (clr) begin
      data_r    <= WORD_ZERO;
      out_fmt_r <= 3'h0;
    end else if (stat_go) begin
      data_r    <= {stat_r, base_r ? o_base_addr[15:0] : 16'h0000};
      out_fmt_r <= FMT_STATUS;
    end else if (out_go) begin
      data_r    <= i_out_xfer.data;
      out_fmt_r <= i_out_xfer.code;
    end else if (host_wr && i_host_addr[2] && state_r == ST_IN_GRANT) begin
      data_r[lane_lsb(i_host_addr) +: 8] <= i_host_wdata;
    end
  end

  // Consumed input handed to the engine
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_in_valid <= 1'b0;
      o_in_xfer  <= '0;
    end else begin
      o_in_valid <= consume && !procedure_error && !clr;
      o_in_xfer  <= '{code: in_type_r, data: data_r};
    end
  end

  // ****************************************************************
  // Base table and control input
  // ****************************************************************
  // Base assignment holds until the next clear
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_r      <= 1'b0;
      o_base_addr <= 18'h00000;
      o_resume    <= 1'b0;
    end else if (clr) begin
      base_r      <= 1'b0;
      o_base_addr <= 18'h00000;
      o_resume    <= 1'b0;
    end else if (consume && !procedure_error && in_type_r[1:0] == CODE_BASE) begin
      base_r      <= 1'b1;
      o_base_addr <= {data_r[31:16+HW_ADDR_LSB], data_r[15:0]};
      o_resume    <= data_r[16+HW_RESUME];
    end
  end

  // Duplex and station selection
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_half_duplex <= 1'b0;
      o_secondary   <= 1'b0;
    end else if (clr) begin
      o_half_duplex <= 1'b0;
      o_secondary   <= 1'b0;
    end else if (consume && !procedure_error && in_type_r[1:0] == CODE_CTL) begin
      o_half_duplex <= data_r[16+HW_HD_BIT];
      o_secondary   <= data_r[16+HW_SEC_BIT];
    end
  end

  // Start-up waits for the next interval tick after base assignment
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      start_pend_r <= 1'b0;
      o_link_start <= 1'b0;
    end else if (clr) begin
      start_pend_r <= 1'b0;
      o_link_start <= 1'b0;
    end else begin
      o_link_start <= start_pend_r && tick && !o_fatal;
      if (consume && !procedure_error && in_type_r[1:0] == CODE_BASE && !data_r[16+HW_RESUME]) begin
        start_pend_r <= 1'b1;
      end else if (tick) begin
        start_pend_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Fatal status and status output
  // ****************************************************************
  // Sticky error bits; an event beats the launch that clears pending
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stat_r      <= 16'h0000;
      stat_pend_r <= 1'b0;
    end else if (clr) begin
      stat_r      <= 16'h0000;
      stat_pend_r <= 1'b0;
    end else begin
      if (i_bus_timeout) begin
        stat_r[HW_ST_TMO] <= 1'b1;
      end
      if (procedure_error) begin
        stat_r[HW_ST_PROC] <= 1'b1;
      end
      if (i_peer_restart && i_link_running) begin
        stat_r[HW_ST_PEER] <= 1'b1;
      end
      if (i_bus_timeout || procedure_error || (i_peer_restart && i_link_running)) begin
        stat_pend_r <= 1'b1;
      end else if (stat_go) begin
        stat_pend_r <= 1'b0;
      end
    end
  end
  assign o_fatal  = stat_r[HW_ST_TMO] || stat_r[HW_ST_PROC] || stat_r[HW_ST_PEER];
  assign o_online = base_r && !o_fatal;

  // ****************************************************************
  // Host read data and interrupts
  // ****************************************************************
  // Registered read return
  always_ff @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_host_rdata <= BYTE_ZERO;
    end else if (i_host_rd) begin
      case (i_host_addr)
        ADDR_CMD:   o_host_rdata <= {state_r == ST_IN_GRANT, in_ien_r, in_req_r, 2'h0,
                                     in_type_r};
        ADDR_MAINT: o_host_rdata <= {1'b0, clr, 6'h00};
        ADDR_RESP:  o_host_rdata <= {state_r == ST_OUT_BUSY, out_ien_r, 3'h0, out_fmt_r};
        3'h4, 3'h5, 3'h6, 3'h7: o_host_rdata <= data_r[lane_lsb(i_host_addr) +: 8];
        default:    o_host_rdata <= BYTE_ZERO;
      endcase
    end
  end

  // Level requests, so an enable set after the flag still interrupts
  assign o_irq_in_vec  = in_ien_r && (state_r == ST_IN_GRANT);
  assign o_irq_out_vec = out_ien_r && (state_r == ST_OUT_BUSY);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_granted;
    state_r == ST_IN_GRANT;
  endsequence
  sequence s_req_dropped;
    s_granted ##0 !in_req_r;
  endsequence

  a_port_one_owner: assert property (
    !(state_r == ST_IN_GRANT && o_out_ready) && !(o_irq_in_vec && o_irq_out_vec))
    else $error("grant and output ready both set");
  a_grant_after_req: assert property (
    $rose(state_r == ST_IN_GRANT) |-> $past(in_req_r) && !$past(o_fatal))
    else $error("grant without request");
  a_grant_consumed: assert property (
    s_req_dropped ##0 !clr |=> state_r == ST_IDLE && (o_in_valid || stat_r[HW_ST_PROC]))
    else $error("dropped request not consumed");
  a_in_irq_level: assert property (s_granted ##0 in_req_r && host_wr
    && i_host_addr == ADDR_CMD && i_host_wdata[CMD_IEN_BIT] |=> o_irq_in_vec)
    else $error("grant interrupt missing");
  a_out_free_port: assert property (
    $rose(state_r == ST_OUT_BUSY) |-> $past(state_r) == ST_IDLE && !$past(in_req_r))
    else $error("output started on busy port");
  a_out_needs_init: assert property (
    $rose(state_r == ST_OUT_BUSY) |-> $past(base_r) && !$past(clr))
    else $error("output before initialization");
  a_out_irq_order: assert property (
    out_ien_r && $rose(state_r == ST_OUT_BUSY) |-> o_irq_out_vec && !$past(o_irq_out_vec))
    else $error("output interrupt timing wrong");
  a_out_holds_grant: assert property (state_r == ST_OUT_BUSY && in_req_r && !clr
    && !(host_wr && i_host_addr == ADDR_RESP) |=> state_r == ST_OUT_BUSY)
    else $error("grant while output pending");
  a_clear_restarts: assert property (
    clr |=> state_r == ST_IDLE && !base_r && !o_fatal && !o_link_start)
    else $error("clear did not restart");
  a_timeout_fatal: assert property (
    i_bus_timeout && !clr |=> stat_r[HW_ST_TMO] && o_fatal)
    else $error("timeout bit not set");
  a_proc_fatal: assert property (
    procedure_error && !clr |=> stat_r[HW_ST_PROC] && !o_in_valid)
    else $error("procedure error not flagged");
  a_start_on_tick: assert property (
    o_link_start |-> $past(tick) && $past(start_pend_r))
    else $error("start-up off interval");
  a_status_format: assert property (
    stat_go && !clr |=> out_fmt_r == FMT_STATUS && data_r[31:16] == $past(stat_r))
    else $error("status output malformed");

endmodule

/* test/tb_top.sv */
// Self-checking bench for the host data port handshake
`timescale 1ns/1ns
module tb_top;
  import hdp_pkg::*;
  logic        clk, rst_n, binit, wr, rd, ov, tmo, peer, run;
  logic [2:0]  addr;
  logic [7:0]  wd, rdat, d;
  hdp_xfer_t   ox, ix;
  logic        ordy, ivld, irqi, irqo, lstart, online, fatal, res, hd, sec;
  logic [17:0] base;
  logic [10:0] rows [8];
  int          bad_count, tests_run;

  hdp_port_ctrl #(.TMR_PRI(20), .TMR_SEC(60)) u_hdp_port_ctrl (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_bus_init(binit), .i_host_addr(addr),
    .i_host_wr(wr), .i_host_rd(rd), .i_host_wdata(wd), .o_host_rdata(rdat),
    .o_irq_in_vec(irqi), .o_irq_out_vec(irqo), .i_out_valid(ov), .i_out_xfer(ox),
    .o_out_ready(ordy), .o_in_valid(ivld), .o_in_xfer(ix), .i_bus_timeout(tmo),
    .i_peer_restart(peer), .i_link_running(run), .o_base_addr(base), .o_resume(res),
    .o_half_duplex(hd), .o_secondary(sec), .o_link_start(lstart),
    .o_online(online), .o_fatal(fatal));

  // ****************************************************************
  // Host access tasks
  // ****************************************************************
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrb(input logic [2:0] a, input logic [7:0] v);
    @(negedge clk);
    addr = a;
    wd = v;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdb(input logic [2:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdat;
  endtask
  // Poll one register bit, bounded
  task automatic wait_rd(input logic [2:0] a, input int b);
    for (int k = 0; k < 40; k++) begin
      rdb(a);
      if (d[b] === 1'b1) break;
    end
  endtask
  task automatic wsig(ref logic s, input int n);
    for (int k = 0; k < n && s !== 1'b1; k++) @(negedge clk);
  endtask
  // Request the port and wait for the grant
  task automatic req(input logic [7:0] c);
    wrb(ADDR_CMD, c);
    wait_rd(ADDR_CMD, CMD_GNT_BIT);
    chk("grant", d[CMD_GNT_BIT], 1'b1);
  endtask
  // Load the port, drop the request, see the data consumed
  task automatic fin(input logic [2:0] t, input logic [31:0] v);
    for (int k = 0; k < 4; k++) wrb(ADDR_DATA + 3'(k), v[8*k +: 8]);
    wrb(ADDR_CMD, {5'h0, t});
    wsig(ivld, 10);
    chk("in xfer", ix, {t, v});
  endtask
  task automatic rd4(input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      rdb(ADDR_DATA + 3'(k));
      chk("port byte", d, v[8*k +: 8]);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #100000;
    bad_count++;
    results();
  end

  // Main sequence
  initial begin
    {rst_n, binit, wr, rd, ov, tmo, peer, run} = '0;
    addr = '0;
    wd = '0;
    ox = '0;
    bad_count = 0;
    tests_run = 0;
    rows = '{11'h000, 11'h100, 11'h200, 11'h300, 11'h400, 11'h500, 11'h600, 11'h700};
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      rdb(rows[k][10:8]);
      chk("reset byte", d, rows[k][7:0]);
    end
    // Base, then control input
    req(8'h23);
    fin(3'h3, 32'h8000_1234);
    chk("base", base, 18'h2_1234);
    chk("online", {online, res}, 2'b10);
    wsig(lstart, 30);
    chk("link start", lstart, 1'b1);
    req(8'h21);
    fin(3'h1, 32'h0c00_0000);
    chk("duplex", {hd, sec}, 2'b11);
    // Output seizes the idle port
    wrb(ADDR_RESP, 8'h40);
    ox = {3'h0, 32'hcafe_0001};
    ov = 1'b1;
    for (int k = 0; k < 20 && ordy !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    ov = 1'b0;
    @(negedge clk);
    chk("irq out", irqo, 1'b1);
    rdb(ADDR_RESP);
    chk("resp", d, 8'hc0);
    rd4(32'hcafe_0001);
    // Request held off until ready is cleared
    wrb(ADDR_CMD, 8'h60);
    repeat (10) @(negedge clk);
    rdb(ADDR_CMD);
    chk("blocked", {d[CMD_GNT_BIT], irqi}, 2'b00);
    wrb(ADDR_RESP, 8'h40);
    req(8'h60);
    chk("irq in", {irqi, irqo}, 2'b10);
    ov = 1'b1;
    repeat (3) @(negedge clk);
    chk("out while granted", ordy, 1'b0);
    ov = 1'b0;
    fin(3'h0, 32'h0000_0100);
    // Invalid type gives a fatal status output
    wrb(ADDR_CMD, 8'h22);
    repeat (5) @(negedge clk);
    wrb(ADDR_CMD, 8'h02);
    wsig(fatal, 20);
    chk("fatal", {fatal, online}, 2'b10);
    wait_rd(ADDR_RESP, RESP_RDY_BIT);
    chk("status fmt", d, 8'hc1);
    rd4(32'h0200_1234);
    wrb(ADDR_RESP, 8'h00);
    // Soft clear restarts everything
    wrb(ADDR_MAINT, 8'h40);
    repeat (205) @(negedge clk);
    chk("cleared", {fatal, online}, 2'b00);
    ov = 1'b1;
    repeat (10) @(negedge clk);
    chk("no output", ordy, 1'b0);
    ov = 1'b0;
    req(8'h23);
    fin(3'h3, 32'h0000_00aa);
    run = 1'b1;
    @(negedge clk);
    tmo = 1'b1;
    peer = 1'b1;
    @(negedge clk);
    {tmo, peer} = 2'b00;
    wait_rd(ADDR_RESP, RESP_RDY_BIT);
    chk("status fmt", d, 8'h81);
    rd4(32'h0180_00aa);
    wrb(ADDR_RESP, 8'h00);
    chk("fatal", fatal, 1'b1);
    // Bus init acts as a clear
    @(negedge clk);
    binit = 1'b1;
    @(negedge clk);
    binit = 1'b0;
    repeat (205) @(negedge clk);
    chk("init", {fatal, online, base}, 20'h0);
    // Base with resume set
    req(8'h23);
    fin(3'h3, 32'h1000_0055);
    chk("resume", {res, base}, {1'b1, 18'h0_0055});
    results();
  end
endmodule
